// ===== bench/tb_rhgs_top.sv
// Self-checking bench for the root hub global status register
module tb_rhgs_top;
  timeunit 1ns;
  timeprecision 1ps;
  import rhgs_pkg::*;
  // ==========================================
  // Stimulus and observed signals
  logic clk = 1'h0, srst = 1'h1, wr = 1'h0, rd = 1'h0, mode = 1'h0, ocpp = 1'h0;
  logic ocpin = 1'h0, susp = 1'h0, resume;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata;
  logic [4:1] mask = 4'h0, pset = 4'h0, pclr = 4'h0, cc = 4'h0, pwr, pexp;
  int err_total = 0, checks = 0;
  always #25 clk = ~clk;
  rhgs_top #(.NPORTS(4)) DUT (.CLK_IN(clk), .SRST_IN(srst), .REG_WR_IN(wr), .REG_RD_IN(rd),
    .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .POWER_MODE_IN(mode), .OC_PER_PORT_IN(ocpp),
    .PORT_POWER_MASK_IN(mask), .PORT_SET_POWER_IN(pset), .PORT_CLEAR_POWER_IN(pclr),
    .OVERCURRENT_PIN_IN(ocpin), .CONNECT_CHANGE_IN(cc), .SUSPENDED_STATE_IN(susp),
    .REG_RDATA_OUT(rdata), .PORT_POWER_OUT(pwr), .RESUME_EVENT_OUT(resume));
  // ==========================================
  // Helpers
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(negedge clk);
    wr = 1'h1; addr = a; wdata = d;
    @(negedge clk);
    wr = 1'h0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp);
    @(negedge clk);
    rd = 1'h1; addr = a;
    @(negedge clk);
    rd = 1'h0;
    chk(rdata, exp);
  endtask : rd_reg
  function automatic logic [31:0] reg_val(input int wk, input int ch, input int oc);
    reg_val = {14'h0, ch[0], 1'h0, wk[0], 13'h0, oc[0], 1'h0};
  endfunction : reg_val
  function automatic logic [4:1] nxt(input logic [4:1] cur, input logic [4:1] gs,
    input logic [4:1] gc, input logic [4:1] ps, input logic [4:1] pc);
    logic [4:1] g;
    g = mode ? ~mask : 4'hf;
    nxt = (cur | (g & gs)) & ~(g & gc);
    if (mode)
      nxt = (nxt | (mask & ps)) & ~(mask & pc);
  endfunction : nxt
  task automatic cc_pulse(input logic s, input logic exp);
    @(negedge clk);
    susp = s; cc = 4'($urandom_range(1, 15));
    @(negedge clk);
    cc = 4'h0;
    chk({31'h0, resume}, {31'h0, exp});
  endtask : cc_pulse
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : wrap_up
  // ==========================================
  // Tests
  initial
  begin
    #200000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    void'($urandom(47161));
    pexp = 4'h0;
    repeat (16) @(negedge clk);
    srst = 1'h0;
    rd_reg(RHGS_ADDR, RHGS_RESET);
    chk({28'h0, pwr}, 32'h0);
    $display("reset test done");
    cc_pulse(1'h1, 1'h0);
    wr_reg(RHGS_ADDR, 32'h0000_8000);
    rd_reg(RHGS_ADDR, reg_val(1, 0, 0));
    cc_pulse(1'h1, 1'h1);
    cc_pulse(1'h0, 1'h0);
    wr_reg(RHGS_ADDR, 32'h0);
    rd_reg(RHGS_ADDR, reg_val(1, 0, 0));
    wr_reg(8'($urandom_range(0, 79)), 32'h8000_0000);
    rd_reg(RHGS_ADDR, reg_val(1, 0, 0));
    rd_reg(8'h54, 32'h0);
    wr_reg(RHGS_ADDR, 32'h8000_8000);
    rd_reg(RHGS_ADDR, reg_val(0, 0, 0));
    $display("wake test done");
    for (int i = 0; i < 12; i++)
    begin
      mode = i[2];
      mask = 4'($urandom());
      pset = 4'($urandom());
      @(negedge clk);
      pexp = nxt(pexp, 4'h0, 4'h0, pset, 4'h0);
      pset = 4'h0;
      chk({28'h0, pwr}, {28'h0, pexp});
      wr_reg(RHGS_ADDR, {15'h0, i[0], 15'h0, i[1]});
      pexp = nxt(pexp, {4{i[0]}}, {4{i[1]}}, 4'h0, 4'h0);
      chk({28'h0, pwr}, {28'h0, pexp});
      pclr = 4'($urandom());
      @(negedge clk);
      pexp = nxt(pexp, 4'h0, 4'h0, 4'h0, pclr);
      pclr = 4'h0;
      chk({28'h0, pwr}, {28'h0, pexp});
      rd_reg(RHGS_ADDR, reg_val(0, 0, 0));
    end
    $display("power test done");
    ocpin = 1'h1;
    repeat (8) @(negedge clk);
    rd_reg(RHGS_ADDR, reg_val(0, 1, 1));
    wr_reg(RHGS_ADDR, 32'h0);
    rd_reg(RHGS_ADDR, reg_val(0, 1, 1));
    wr_reg(RHGS_ADDR, 32'h0002_0000);
    rd_reg(RHGS_ADDR, reg_val(0, 0, 1));
    ocpp = 1'h1;
    repeat (8) @(negedge clk);
    rd_reg(RHGS_ADDR, reg_val(0, 1, 0));
    ocpp = 1'h0;
    repeat (8) @(negedge clk);
    rd_reg(RHGS_ADDR, reg_val(0, 1, 1));
    wr_reg(RHGS_ADDR, 32'h0002_0000);
    rd_reg(RHGS_ADDR, reg_val(0, 0, 1));
    ocpin = 1'h0;
    repeat (8) @(negedge clk);
    rd_reg(RHGS_ADDR, reg_val(0, 1, 0));
    wr_reg(RHGS_ADDR, 32'h0002_0000);
    rd_reg(RHGS_ADDR, reg_val(0, 0, 0));
    $display("overcurrent test done");
    wrap_up();
  end
endmodule : tb_rhgs_top

// ===== src/rhgs_pkg.sv
// Constants for the root hub global status register block
package rhgs_pkg;
  localparam logic [7:0] RHGS_ADDR = 8'h50;
  localparam int RHGS_NPORTS = 4;
  localparam int RHGS_BIT_CLR_WAKE = 31;
  localparam int RHGS_BIT_OC_CHANGE = 17;
  localparam int RHGS_BIT_SET_POWER = 16;
  localparam int RHGS_BIT_WAKE = 15;
  localparam int RHGS_BIT_OC = 1;
  localparam int RHGS_BIT_CLR_POWER = 0;
  localparam logic [31:0] RHGS_RESET = 32'h0000_0000;
  localparam logic RHGS_FLAG_RESET = 1'h0;
  localparam logic RHGS_MODE_GLOBAL = 1'h0;
endpackage : rhgs_pkg

// ===== src/rhgs_port_power.sv
// Power state of one downstream port
module rhgs_port_power
  import rhgs_pkg::*;
(
  input wire logic clk_in,
  input wire logic srst_in,
  input wire logic mode_in,
  input wire logic mask_in,
  input wire logic global_set_in,
  input wire logic global_clear_in,
  input wire logic port_set_in,
  input wire logic port_clear_in,
  output logic power_out
);
  logic follows_global;
  logic follows_port;

  // ==========================================
  // Command steering
  assign follows_global = (mode_in == RHGS_MODE_GLOBAL) || !mask_in;
  assign follows_port = (mode_in != RHGS_MODE_GLOBAL) && mask_in;

  // ==========================================
  // Power state
  always_ff @(posedge clk_in)
  begin
    if (srst_in)
    begin
      power_out <= RHGS_FLAG_RESET;
    end
    else if (follows_global && global_clear_in)
    begin
      power_out <= 1'h0;
    end
    else if (follows_global && global_set_in)
    begin
      power_out <= 1'h1;
    end
    else if (follows_port && port_clear_in)
    begin
      power_out <= 1'h0;
    end
    else if (follows_port && port_set_in)
    begin
      power_out <= 1'h1;
    end
  end
endmodule : rhgs_port_power

// ===== src/rhgs_top.sv
// Root hub global status register with power, overcurrent and wake logic
module rhgs_top
  import rhgs_pkg::*;
#(
  parameter int NPORTS = RHGS_NPORTS
)
(
  input wire logic CLK_IN,
  input wire logic SRST_IN,
  input wire logic REG_WR_IN,
  input wire logic REG_RD_IN,
  input wire logic [7:0] REG_ADDR_IN,
  input wire logic [31:0] REG_WDATA_IN,
  input wire logic POWER_MODE_IN,
  input wire logic OC_PER_PORT_IN,
  input wire logic [NPORTS:1] PORT_POWER_MASK_IN,
  input wire logic [NPORTS:1] PORT_SET_POWER_IN,
  input wire logic [NPORTS:1] PORT_CLEAR_POWER_IN,
  input wire logic OVERCURRENT_PIN_IN,
  input wire logic [NPORTS:1] CONNECT_CHANGE_IN,
  input wire logic SUSPENDED_STATE_IN,
  output logic [31:0] REG_RDATA_OUT,
  output logic [NPORTS:1] PORT_POWER_OUT,
  output logic RESUME_EVENT_OUT
);
  import rhgs_pkg::*;

  logic hit_wr;
  logic set_power_strobe;
  logic clear_power_strobe;
  logic set_wake_strobe;
  logic clear_wake_strobe;
  logic clear_change_strobe;
  logic remote_wake_enable_reg;
  logic overcurrent_change_flag_reg;
  logic global_overcurrent_indicator_reg;
  logic global_overcurrent_indicator_next;
  logic oc_sync1_reg;
  logic oc_sync2_reg;
  logic oc_sync3_reg;
  logic [31:0] read_value;

  // ==========================================
  // Write decode
  assign hit_wr = REG_WR_IN && (REG_ADDR_IN == RHGS_ADDR);
  assign set_power_strobe = hit_wr && REG_WDATA_IN[RHGS_BIT_SET_POWER];
  assign clear_power_strobe = hit_wr && REG_WDATA_IN[RHGS_BIT_CLR_POWER];
  assign set_wake_strobe = hit_wr && REG_WDATA_IN[RHGS_BIT_WAKE];
  assign clear_wake_strobe = hit_wr && REG_WDATA_IN[RHGS_BIT_CLR_WAKE];
  assign clear_change_strobe = hit_wr && REG_WDATA_IN[RHGS_BIT_OC_CHANGE];

  // ==========================================
  // Remote wake-up enable
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      remote_wake_enable_reg <= RHGS_FLAG_RESET;
    end
    else if (clear_wake_strobe)
    begin
      remote_wake_enable_reg <= 1'h0;
    end
    else if (set_wake_strobe)
    begin
      remote_wake_enable_reg <= 1'h1;
    end
  end

  // ==========================================
  // Overcurrent pin synchroniser
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      oc_sync1_reg <= 1'h0;
      oc_sync2_reg <= 1'h0;
      oc_sync3_reg <= 1'h0;
    end
    else
    begin
      oc_sync1_reg <= OVERCURRENT_PIN_IN;
      oc_sync2_reg <= oc_sync1_reg;
      oc_sync3_reg <= oc_sync2_reg;
    end
  end

  // ==========================================
  // Global overcurrent indicator
  always_comb
  begin
    global_overcurrent_indicator_next = global_overcurrent_indicator_reg;
    if (OC_PER_PORT_IN)
    begin
      global_overcurrent_indicator_next = 1'h0;
    end
    else if (oc_sync2_reg == oc_sync3_reg)
    begin
      global_overcurrent_indicator_next = oc_sync3_reg;
    end
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      global_overcurrent_indicator_reg <= RHGS_FLAG_RESET;
    end
    else
    begin
      global_overcurrent_indicator_reg <= global_overcurrent_indicator_next;
    end
  end

  // ==========================================
  // Overcurrent change flag, set wins over clear
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      overcurrent_change_flag_reg <= RHGS_FLAG_RESET;
    end
    else if (global_overcurrent_indicator_next != global_overcurrent_indicator_reg)
    begin
      overcurrent_change_flag_reg <= 1'h1;
    end
    else if (clear_change_strobe)
    begin
      overcurrent_change_flag_reg <= 1'h0;
    end
  end

  // ==========================================
  // Port power cells
  for (genvar p = 1; p <= NPORTS; p++)
  begin : g_port
    rhgs_port_power u_port (
      .clk_in(CLK_IN),
      .srst_in(SRST_IN),
      .mode_in(POWER_MODE_IN),
      .mask_in(PORT_POWER_MASK_IN[p]),
      .global_set_in(set_power_strobe),
      .global_clear_in(clear_power_strobe),
      .port_set_in(PORT_SET_POWER_IN[p]),
      .port_clear_in(PORT_CLEAR_POWER_IN[p]),
      .power_out(PORT_POWER_OUT[p])
    );
  end

  // ==========================================
  // Resume event
  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      RESUME_EVENT_OUT <= 1'h0;
    end
    else
    begin
      RESUME_EVENT_OUT <= remote_wake_enable_reg && SUSPENDED_STATE_IN
        && (|CONNECT_CHANGE_IN);
    end
  end

  // ==========================================
  // Read path
  always_comb
  begin
    read_value = RHGS_RESET;
    read_value[RHGS_BIT_OC_CHANGE] = overcurrent_change_flag_reg;
    read_value[RHGS_BIT_WAKE] = remote_wake_enable_reg;
    read_value[RHGS_BIT_OC] = global_overcurrent_indicator_reg;
  end

  always_ff @(posedge CLK_IN)
  begin
    if (SRST_IN)
    begin
      REG_RDATA_OUT <= RHGS_RESET;
    end
    else if (REG_RD_IN && (REG_ADDR_IN == RHGS_ADDR))
    begin
      REG_RDATA_OUT <= read_value;
    end
    else
    begin
      REG_RDATA_OUT <= RHGS_RESET;
    end
  end

  // ==========================================
  // Assertions
  default clocking cb @(posedge CLK_IN); endclocking
  default disable iff (SRST_IN);

  a_wake_clear: assert property (
    clear_wake_strobe |=> !remote_wake_enable_reg)
    else $error("wake enable not cleared");
  a_wake_set: assert property (
    set_wake_strobe && !clear_wake_strobe |=> remote_wake_enable_reg)
    else $error("wake enable not set");
  a_oc_change: assert property (
    $changed(global_overcurrent_indicator_reg)
    |-> overcurrent_change_flag_reg)
    else $error("change flag missed");
  a_oc_clear: assert property (
    clear_change_strobe && $stable(global_overcurrent_indicator_reg)
    && (global_overcurrent_indicator_next == global_overcurrent_indicator_reg)
    |=> !overcurrent_change_flag_reg)
    else $error("change flag not cleared");
  a_read_zeros: assert property (
    REG_RDATA_OUT[RHGS_BIT_SET_POWER] == 1'h0 && REG_RDATA_OUT[RHGS_BIT_CLR_POWER] == 1'h0
    && REG_RDATA_OUT[RHGS_BIT_CLR_WAKE] == 1'h0)
    else $error("constant zero bit read as one");
  a_oc_filter: assert property (
    !OC_PER_PORT_IN && (oc_sync2_reg == oc_sync3_reg) ##1 1'h1
    |-> global_overcurrent_indicator_reg == $past(oc_sync3_reg))
    else $error("overcurrent indicator wrong");
  a_oc_perport: assert property (
    OC_PER_PORT_IN |=> !global_overcurrent_indicator_reg)
    else $error("indicator set in per-port mode");
  a_resume: assert property (
    remote_wake_enable_reg && SUSPENDED_STATE_IN && (|CONNECT_CHANGE_IN)
    |=> RESUME_EVENT_OUT)
    else $error("resume event missed");
  a_no_resume: assert property (
    !remote_wake_enable_reg |=> !RESUME_EVENT_OUT)
    else $error("resume without wake enable");
  a_global_off: assert property (
    clear_power_strobe && POWER_MODE_IN == RHGS_MODE_GLOBAL |=> PORT_POWER_OUT == '0)
    else $error("ports still powered");
  a_global_on: assert property (
    set_power_strobe && !clear_power_strobe && POWER_MODE_IN == RHGS_MODE_GLOBAL
    |=> PORT_POWER_OUT == '1)
    else $error("ports not powered");
  a_read_layout: assert property (
    REG_RD_IN && (REG_ADDR_IN == RHGS_ADDR)
    |=> REG_RDATA_OUT[RHGS_BIT_WAKE] == $past(remote_wake_enable_reg)
    && REG_RDATA_OUT[RHGS_BIT_OC_CHANGE] == $past(overcurrent_change_flag_reg))
    else $error("read layout wrong");
endmodule : rhgs_top
